/* File: inc/serial_port_pkg.sv */
// Constants and types for the dual-mode serial slave port
package serial_port_pkg;
  // Timing
  localparam int CLK_HZ = 25_000_000;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int TMO_W = 20;
  // Two-wire slave address
  localparam logic [3:0] ADDR_UPPER = 4'h9;
  localparam logic [2:0] ADDR_LSB_LOW = 3'h0;
  localparam logic [2:0] ADDR_LSB_FLOAT = 3'h2;
  localparam logic [2:0] ADDR_LSB_HIGH = 3'h3;
  // Strap sense codes from the pad detector
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_HIGH = 2'h2;
  // Four-wire command bytes
  localparam logic [7:0] SPI_CMD_WRITE = 8'h90;
  localparam logic [7:0] SPI_CMD_READ = 8'h91;
  // Lock status register
  localparam logic [7:0] LOCK_STATE_ADDR = 8'h7F;
  localparam int LOCK_BIT = 0;
  localparam logic [7:0] LOCK_STATE_RESET = 8'h00;
  localparam logic [1:0] CS_RISES_TO_LOCK = 2'h3;
  // Pointer
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] SPI_PTR_LAST = 8'h3F;
  localparam logic [7:0] SPI_PTR_FIRST = 8'h00;
  // Packet error check
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_WR,
    S_WR_ACK,
    S_RD,
    S_RD_ACK
  } i2c_state_e;
endpackage

/* File: hdl/dual_serial_slave_port.sv */
// Dual-mode two-wire / four-wire serial slave port with SPI lock
`timescale 1ns/100ps
module dual_serial_slave_port #(
  parameter int unsigned TIMEOUT_CYCLES = serial_port_pkg::TIMEOUT_CYCLES,
  parameter int TMO_W = serial_port_pkg::TMO_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_n_o,
  input wire logic [1:0] add_sel_i,
  input wire logic timeout_en_i,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_wr_o,
  input wire logic [7:0] reg_rdata_i,
  output logic spi_locked_o
);

  // Byte-wise CRC-8 update
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ serial_port_pkg::CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  serial_port_pkg::i2c_state_e st_reg;
  logic [2:0] scl_sync_reg, sda_sync_reg, cs_sync_reg, tog_sync_reg;
  logic [3:0] add_sync_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sh_reg, crc_reg, ptr_reg, addr_reg, wdata_reg, tx_hold_reg;
  logic [1:0] byte_idx_reg, seen_reg, lock_cnt_reg, spi_idx_reg;
  logic rw_reg, sda_low_reg, latched_reg, lock_reg, wr_reg;
  logic spi_rd_reg, spi_wr_reg;
  logic [6:0] latch_addr_reg;
  logic [TMO_W-1:0] tmo_reg;
  // Link-clock side
  logic [2:0] sbit_reg;
  logic [6:0] ssh_reg;
  logic first_done_reg, rd_phase_reg, tog_reg;
  logic [7:0] rx_hold_reg, tx_reg;

  // Synchronised pins and edges
  wire scl_h = scl_sync_reg[1];
  wire sda_h = sda_sync_reg[1];
  wire scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
  wire scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
  wire start_w = scl_h & scl_sync_reg[2] & ~sda_h & sda_sync_reg[2];
  wire stop_w = scl_h & scl_sync_reg[2] & sda_h & ~sda_sync_reg[2];
  wire cs_high = cs_sync_reg[1];
  wire cs_rise = cs_sync_reg[1] & ~cs_sync_reg[2];
  wire spi_ev = tog_sync_reg[1] ^ tog_sync_reg[2];

  // Strap decode and address compare
  wire [1:0] strap = add_sync_reg[3:2];
  wire [2:0] strap_lsb = (strap == serial_port_pkg::STRAP_HIGH) ?
    serial_port_pkg::ADDR_LSB_HIGH : (strap == serial_port_pkg::STRAP_FLOAT) ?
    serial_port_pkg::ADDR_LSB_FLOAT : serial_port_pkg::ADDR_LSB_LOW;
  wire [6:0] strap_addr = {serial_port_pkg::ADDR_UPPER, strap_lsb};
  wire [6:0] dev_addr = latched_reg ? latch_addr_reg : strap_addr;
  wire byte_end = scl_fall && (bit_cnt_reg == serial_port_pkg::BITS_PER_BYTE);
  wire addr_done = (st_reg == serial_port_pkg::S_ADDR) && byte_end;
  wire addr_match = addr_done && (sh_reg[7:1] == dev_addr);

  // Write-phase decode; a byte after the pointer byte that equals the running CRC is a packet check
  wire wr_done = (st_reg == serial_port_pkg::S_WR) && byte_end;
  wire i2c_ptr_ld = wr_done && (byte_idx_reg == 2'h0);
  wire i2c_pec = wr_done && (byte_idx_reg != 2'h0) && (sh_reg == crc_reg);
  wire i2c_wr = wr_done && (byte_idx_reg != 2'h0) && !i2c_pec;
  wire rd_load = scl_fall && ((st_reg == serial_port_pkg::S_RD_ACK) ||
    ((st_reg == serial_port_pkg::S_ADDR_ACK) && rw_reg));
  wire is_lock_addr = (addr_reg == serial_port_pkg::LOCK_STATE_ADDR);
  wire [7:0] lock_view = {7'h00, lock_reg};
  wire [7:0] rd_mux = is_lock_addr ? lock_view : reg_rdata_i;
  wire [7:0] rd_byte = (byte_idx_reg == 2'h0) ? rd_mux : crc_reg;
  wire tmo_hit = (tmo_reg == TMO_W'(TIMEOUT_CYCLES - 1));
  wire i2c_abort = lock_reg || stop_w || tmo_hit;

  // Four-wire byte events in the reference domain
  wire [7:0] rx = rx_hold_reg;
  wire spi_go = lock_reg && spi_ev;
  wire spi_cmd = spi_go && (spi_idx_reg == 2'h0);
  wire cmd_is_rd = (rx == serial_port_pkg::SPI_CMD_READ);
  wire cmd_is_wr = (rx == serial_port_pkg::SPI_CMD_WRITE);
  wire spi_rd_inc = spi_go && (spi_cmd ? cmd_is_rd : spi_rd_reg);
  wire spi_ptr_ld = spi_go && (spi_idx_reg == 2'h1) && spi_wr_reg;
  wire spi_wr = spi_go && (spi_idx_reg[1]) && spi_wr_reg;
  wire spi_inc = spi_rd_inc || spi_wr;
  wire [7:0] ptr_inc = (ptr_reg == serial_port_pkg::SPI_PTR_LAST) ?
    serial_port_pkg::SPI_PTR_FIRST : ptr_reg + 8'h01;
  wire [7:0] ptr_next = i2c_ptr_ld ? sh_reg : spi_ptr_ld ? rx :
    spi_inc ? ptr_inc : ptr_reg;
  wire wr_any = i2c_wr || spi_wr;
  wire ptr_ro = (ptr_reg == serial_port_pkg::LOCK_STATE_ADDR);

  // Pin synchronisers, first stage feeds only the second
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      cs_sync_reg <= 3'h7;
      tog_sync_reg <= 3'h0;
      add_sync_reg <= 4'h0;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n_i};
      tog_sync_reg <= {tog_sync_reg[1:0], tog_reg};
      add_sync_reg <= {add_sync_reg[1:0], add_sel_i};
    end
  end

  // Interface lock: only the power-on reset clears it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_reg <= serial_port_pkg::LOCK_STATE_RESET[serial_port_pkg::LOCK_BIT];
      lock_cnt_reg <= 2'h0;
    end else if (!lock_reg && cs_rise) begin
      lock_cnt_reg <= lock_cnt_reg + 2'h1;
      if (lock_cnt_reg == serial_port_pkg::CS_RISES_TO_LOCK - 2'h1) begin
        lock_reg <= 1'b1;
      end
    end
  end

  // Two-wire state machine
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= serial_port_pkg::S_IDLE;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      rw_reg <= 1'b0;
      byte_idx_reg <= 2'h0;
      sda_low_reg <= 1'b0;
    end else if (i2c_abort) begin
      st_reg <= serial_port_pkg::S_IDLE;
      sda_low_reg <= 1'b0;
    end else if (start_w) begin
      st_reg <= serial_port_pkg::S_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_low_reg <= 1'b0;
    end else begin
      case (st_reg)
        serial_port_pkg::S_ADDR, serial_port_pkg::S_WR: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_h};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (addr_done) begin
            st_reg <= addr_match ? serial_port_pkg::S_ADDR_ACK : serial_port_pkg::S_IDLE;
            sda_low_reg <= addr_match;
            rw_reg <= sh_reg[0];
            byte_idx_reg <= 2'h0;
          end else if (wr_done) begin
            st_reg <= serial_port_pkg::S_WR_ACK;
            sda_low_reg <= 1'b1;
          end
        end
        serial_port_pkg::S_ADDR_ACK, serial_port_pkg::S_RD_ACK: begin
          if (scl_rise && st_reg == serial_port_pkg::S_RD_ACK && sda_h) begin
            st_reg <= serial_port_pkg::S_IDLE;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (rw_reg) begin
              st_reg <= serial_port_pkg::S_RD;
              sh_reg <= rd_byte;
              sda_low_reg <= ~rd_byte[7];
              byte_idx_reg <= (byte_idx_reg == 2'h3) ? 2'h3 : byte_idx_reg + 2'h1;
            end else begin
              st_reg <= serial_port_pkg::S_WR;
              sda_low_reg <= 1'b0;
            end
          end
        end
        serial_port_pkg::S_WR_ACK: begin
          if (scl_fall) begin
            st_reg <= serial_port_pkg::S_WR;
            sda_low_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            byte_idx_reg <= (byte_idx_reg == 2'h3) ? 2'h3 : byte_idx_reg + 2'h1;
          end
        end
        serial_port_pkg::S_RD: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_end) begin
            st_reg <= serial_port_pkg::S_RD_ACK;
            sda_low_reg <= 1'b0;
          end else if (scl_fall) begin
            sh_reg <= {sh_reg[6:0], 1'b0};
            sda_low_reg <= ~sh_reg[6];
          end
        end
        default: begin
          st_reg <= serial_port_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Running packet check over every byte of the transaction
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      crc_reg <= serial_port_pkg::CRC_INIT;
    end else if (start_w && st_reg == serial_port_pkg::S_IDLE) begin
      crc_reg <= serial_port_pkg::CRC_INIT;
    end else if (addr_done || wr_done) begin
      crc_reg <= crc8(crc_reg, sh_reg);
    end else if (rd_load && byte_idx_reg == 2'h0) begin
      crc_reg <= crc8(crc_reg, rd_mux);
    end
  end

  // Strap address capture on the second matching address byte
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_reg <= 2'h0;
      latched_reg <= 1'b0;
      latch_addr_reg <= 7'h00;
    end else if (addr_match && !latched_reg) begin
      seen_reg <= seen_reg + 2'h1;
      if (seen_reg == 2'h1) begin
        latched_reg <= 1'b1;
        latch_addr_reg <= strap_addr;
      end
    end
  end

  // Inactivity timer, counts only while enabled and outside S_IDLE, including the address byte
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tmo_reg <= '0;
    end else if (!timeout_en_i || st_reg == serial_port_pkg::S_IDLE ||
                 scl_rise || scl_fall || tmo_hit) begin
      tmo_reg <= '0;
    end else begin
      tmo_reg <= tmo_reg + TMO_W'(1);
    end
  end

  // Four-wire transaction tracking, cleared by chip-select high
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      spi_idx_reg <= 2'h0;
      spi_rd_reg <= 1'b0;
      spi_wr_reg <= 1'b0;
    end else if (spi_go) begin
      spi_idx_reg <= (spi_idx_reg == 2'h3) ? 2'h3 : spi_idx_reg + 2'h1;
      if (spi_cmd) begin
        spi_rd_reg <= cmd_is_rd;
        spi_wr_reg <= cmd_is_wr;
      end
    end else if (cs_high) begin
      spi_idx_reg <= 2'h0;
      spi_rd_reg <= 1'b0;
      spi_wr_reg <= 1'b0;
    end
  end

  // Shared pointer and register-file strobes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr_reg <= serial_port_pkg::PTR_RESET;
      addr_reg <= serial_port_pkg::PTR_RESET;
      wr_reg <= 1'b0;
      wdata_reg <= 8'h00;
      tx_hold_reg <= 8'h00;
    end else begin
      ptr_reg <= ptr_next;
      addr_reg <= wr_any ? ptr_reg : ptr_next;
      wr_reg <= wr_any && !ptr_ro;
      wdata_reg <= i2c_wr ? sh_reg : rx;
      tx_hold_reg <= rd_mux;
    end
  end

  // Link clock: receive shifter, reset by chip-select high
  wire spi_arst = rst_i | cs_n_i;
  wire [7:0] rx_byte = {ssh_reg, din_i};
  always_ff @(posedge sclk_i or posedge spi_arst) begin
    if (spi_arst) begin
      sbit_reg <= 3'h0;
      ssh_reg <= 7'h00;
      first_done_reg <= 1'b0;
      rd_phase_reg <= 1'b0;
    end else begin
      sbit_reg <= sbit_reg + 3'h1;
      ssh_reg <= rx_byte[6:0];
      if (sbit_reg == 3'h7) begin
        first_done_reg <= 1'b1;
        if (!first_done_reg) begin
          rd_phase_reg <= (rx_byte == serial_port_pkg::SPI_CMD_READ);
        end
      end
    end
  end

  // Link clock: completed byte and toggle survive chip-select
  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_hold_reg <= 8'h00;
      tog_reg <= 1'b0;
    end else if (sbit_reg == 3'h7) begin
      rx_hold_reg <= rx_byte;
      tog_reg <= ~tog_reg;
    end
  end

  // Link clock: transmit shifter on falling edges
  always_ff @(negedge sclk_i or posedge spi_arst) begin
    if (spi_arst) begin
      tx_reg <= 8'h00;
    end else if (sbit_reg == 3'h0 && first_done_reg) begin
      tx_reg <= tx_hold_reg;
    end else begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  // Pin drivers: open-drain data, four-wire output driven only in a locked read phase
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~sda_low_reg;
  assign dout_o = tx_reg[7];
  assign dout_oe_n_o = ~(rd_phase_reg & lock_reg);
  assign reg_addr_o = addr_reg;
  assign reg_wdata_o = wdata_reg;
  assign reg_wr_o = wr_reg;
  assign spi_locked_o = lock_reg;

  a_lock_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    lock_reg |=> lock_reg)
    else $error("lock state dropped");

  a_lock_third_rise: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!lock_reg && cs_rise && lock_cnt_reg == 2'h2) |=> lock_reg)
    else $error("third chip-select rise did not lock");

  a_lock_not_early: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!lock_reg && !(cs_rise && lock_cnt_reg == 2'h2)) |=> !lock_reg)
    else $error("lock set without third rise");

  a_lock_reads_d0: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    is_lock_addr |-> (rd_mux[0] == spi_locked_o && rd_mux[7:1] == 7'h00))
    else $error("lock status read wrong");

  a_sda_quiet_locked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    lock_reg |=> sda_oe_n_o)
    else $error("data line driven after lock");

  a_ack_on_match: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (addr_match && !i2c_abort && !start_w) |=> !sda_oe_n_o ##0
      (st_reg == serial_port_pkg::S_ADDR_ACK))
    else $error("matched address not acknowledged");

  a_ptr_wrap: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (spi_inc && !spi_ptr_ld && !i2c_ptr_ld && ptr_reg == serial_port_pkg::SPI_PTR_LAST)
      |=> ptr_reg == serial_port_pkg::SPI_PTR_FIRST)
    else $error("pointer did not wrap");

  a_i2c_no_inc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (i2c_wr && !spi_go) |=> (ptr_reg == $past(ptr_reg) && reg_addr_o == ptr_reg))
    else $error("pointer moved on two-wire write");

  a_timeout_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    tmo_hit |=> (st_reg == serial_port_pkg::S_IDLE && sda_oe_n_o))
    else $error("timeout did not release bus");

  a_dout_hiz_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cs_sync_reg[2:1] == 2'h3 |-> dout_oe_n_o)
    else $error("data out driven while deselected");
endmodule

/* File: verification/host_master_model.sv */
// Host master model for the two-wire and four-wire links of the serial port
`timescale 1ns/100ps
module host_master_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i
);
  // Idle bus: clocks still, data released, chip-select high
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
  end
  // Start: data falls while the clock is high
  task automatic i2c_start();
    #200 sda_low_o = 1'b0;
    #200 scl_o = 1'b1;
    #400 sda_low_o = 1'b1;
    #400 scl_o = 1'b0;
  endtask
  // Stop: data rises while the clock is high
  task automatic i2c_stop();
    #200 sda_low_o = 1'b1;
    #200 scl_o = 1'b1;
    #400 sda_low_o = 1'b0;
    #400;
  endtask
  // Eight data bits and the acknowledge slot; data moves only in the low phase
  task automatic i2c_byte(input logic [7:0] tx, input logic ack_bit,
                          output logic [7:0] rx, output logic ack);
    logic [8:0] sh;
    sh = {tx, ack_bit};
    for (int i = 8; i >= 0; i--) begin
      #200 sda_low_o = !sh[i];
      #200 scl_o = 1'b1;
      #200 sh[i] = sda_i;
      #200 scl_o = 1'b0;
    end
    rx = sh[8:1];
    ack = sh[0];
  endtask
  // Chip-select low spans one whole transfer, high between transfers
  task automatic spi_begin();
    cs_n_o = 1'b0;
    #250;
  endtask
  // Data line changes once released so stale values are never reused
  task automatic spi_end();
    #250 cs_n_o = 1'b1;
    din_o = !din_o;
    #250;
  endtask
  // Host owns the link clock; data set while low, read bit taken on the rise
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      din_o = tx[i];
      #62.5 sclk_o = 1'b1;
      rx[i] = dout_i;
      #62.5 sclk_o = 1'b0;
    end
  endtask
endmodule

/* File: verification/dual_serial_slave_port_bench.sv */
// Self-checking bench for the dual-mode serial slave port
`timescale 1ns/100ps
module dual_serial_slave_port_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] add_sel = 2'h0;
  logic tmo_en = 1'b0;
  logic scl, sda_low, cs_n, sclk, din, sda_o, sda_oe_n;
  logic dout, dout_oe_n, reg_wr, locked, ack;
  logic [7:0] reg_addr, reg_wdata, rx;
  logic [7:0] mem [256];
  logic [6:0] adr [3] = '{7'h48, 7'h4A, 7'h4B};
  int error_cnt = 0;
  int checked = 0;
  int wr_cnt = 0;
  // Open-drain data wire with pull-up; data-out pulled up when released
  wire sda_w = !sda_low && (sda_oe_n || sda_o);
  wire dout_w = dout_oe_n ? 1'b1 : dout;
  // Reference clock, 40 ns period
  always #20 ref_clk = !ref_clk;
  // Register file behind the port
  always @(posedge ref_clk) begin
    if (reg_wr === 1'b1) begin
      mem[reg_addr] <= reg_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
  dual_serial_slave_port #(.TIMEOUT_CYCLES(200)) dual_serial_slave_port_i (
    .ref_clk_i(ref_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din), .dout_o(dout),
    .dout_oe_n_o(dout_oe_n), .add_sel_i(add_sel), .timeout_en_i(tmo_en),
    .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr),
    .reg_rdata_i(mem[reg_addr]), .spi_locked_o(locked));
  host_master_model host_master_model_i (
    .scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_w), .cs_n_o(cs_n), .sclk_o(sclk),
    .din_o(din), .dout_i(dout_w));
  // Byte comparison with count
  task automatic check8(input logic [7:0] act, input logic [7:0] exp, input string what);
    checked++;
    if (act !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, act, exp);
    end
  endtask
  // Packet check byte over one more byte
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int k = 0; k < 8; k++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction
  // Power-up with a strap setting
  task automatic do_reset(input logic [1:0] s);
    rst <= 1'b1;
    add_sel <= s;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check8({7'h0, locked}, 8'h00, "lock after reset");
  endtask
  // Two-wire helpers
  task automatic i2c_go();
    host_master_model_i.i2c_start();
  endtask
  task automatic i2c_end();
    host_master_model_i.i2c_stop();
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic put(input logic [7:0] b, input logic exp_nack);
    host_master_model_i.i2c_byte(b, 1'b1, rx, ack);
    check8({7'h0, ack}, {7'h0, exp_nack}, "i2c ack");
  endtask
  task automatic get(input logic nack, input logic [7:0] exp);
    host_master_model_i.i2c_byte(8'hFF, nack, rx, ack);
    check8(rx, exp, "i2c read");
  endtask
  // Four-wire helpers
  task automatic sbeg();
    host_master_model_i.spi_begin();
  endtask
  task automatic send();
    host_master_model_i.spi_end();
  endtask
  task automatic sx(input logic [7:0] tx);
    host_master_model_i.spi_byte(tx, rx);
  endtask
  task automatic srd(input logic [7:0] exp);
    host_master_model_i.spi_byte(8'hFF, rx);
    check8(rx, exp, "spi read");
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #3_000_000;
    error_cnt++;
    $display("MISMATCH t=%0t run limit reached", $time);
    finish_test();
  end
  // Main sequence
  initial begin
    int n;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hC3;
    for (int i = 2; i >= 0; i--) begin
      do_reset(2'(i));
      i2c_go();
      put({adr[i], 1'b0}, 1'b0);
      put(8'h10, 1'b0);
      i2c_end();
      i2c_go();
      put({adr[(i + 1) % 3], 1'b0}, 1'b1);
      i2c_end();
    end
    check8(8'(wr_cnt), 8'h00, "pointer-only write");
    $display("strap test done");
    i2c_go();
    put(8'h90, 1'b0);
    put(8'h10, 1'b0);
    put(8'h55, 1'b0);
    put(8'hA3, 1'b0);
    i2c_end();
    check8(mem[8'h10], 8'hA3, "overwrite");
    check8(mem[8'h11], 8'hD2, "no increment");
    n = wr_cnt;
    i2c_go();
    put(8'h90, 1'b0);
    put(8'h20, 1'b0);
    i2c_end();
    check8(8'(wr_cnt - n), 8'h00, "pointer-only write");
    repeat (2) begin
      i2c_go();
      put(8'h91, 1'b0);
      get(1'b1, 8'hE3);
      i2c_end();
    end
    i2c_go();
    put(8'h91, 1'b0);
    get(1'b0, 8'hE3);
    get(1'b1, crc8(crc8(8'h00, 8'h91), 8'hE3));
    i2c_end();
    i2c_go();
    put(8'h90, 1'b0);
    put(8'h7F, 1'b0);
    i2c_end();
    i2c_go();
    put(8'h91, 1'b0);
    get(1'b1, 8'h00);
    i2c_end();
    $display("two-wire access test done");
    add_sel <= 2'h2;
    i2c_go();
    put(8'h96, 1'b1);
    i2c_end();
    i2c_go();
    put(8'h90, 1'b0);
    i2c_end();
    for (int e = 0; e < 2; e++) begin
      tmo_en <= e[0];
      i2c_go();
      put(8'h90, 1'b0);
      repeat (300) @(posedge ref_clk);
      put(8'h30, e[0]);
      i2c_end();
    end
    $display("latch and timeout test done");
    repeat (3) begin
      sbeg();
      send();
    end
    n = 0;
    while (locked !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    check8({7'h0, locked}, 8'h01, "lock");
    i2c_go();
    put(8'h90, 1'b1);
    i2c_end();
    sbeg();
    sx(8'h90);
    sx(8'h3E);
    sx(8'h11);
    sx(8'h22);
    sx(8'h33);
    send();
    check8(mem[8'h3E], 8'h11, "spi write");
    check8(mem[8'h3F], 8'h22, "spi write");
    check8(mem[8'h00], 8'h33, "spi wrap");
    sbeg();
    sx(8'h90);
    sx(8'h3F);
    send();
    sbeg();
    sx(8'h91);
    srd(8'h22);
    srd(8'h33);
    send();
    check8({7'h0, dout_oe_n}, 8'h01, "dout released");
    sbeg();
    sx(8'h90);
    sx(8'h7F);
    send();
    sbeg();
    sx(8'h91);
    srd(8'h01);
    send();
    $display("four-wire test done");
    do_reset(2'h0);
    i2c_go();
    put(8'h90, 1'b0);
    i2c_end();
    $display("power cycle test done");
    finish_test();
  end
endmodule
